// File: hdl/sahi_regs.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes a 250 MHz system clock and 32-bit APB data.
`ifndef SAHI_REGS_SVH
`define SAHI_REGS_SVH
`define SAHI_OFF_CTRL 8'h00
`define SAHI_OFF_STATUS 8'h04
`define SAHI_OFF_RESULT 8'h08
`define SAHI_CTRL_FMT_LSB 0
`define SAHI_CTRL_EXT_BIT 2
`define SAHI_CTRL_RESET 32'h0000_0000
`define SAHI_CLK_PERIOD_NS 4
`define SAHI_CONV_PERIOD_NS 400
`define SAHI_HALF_CYC ((`SAHI_CONV_PERIOD_NS / 2) / `SAHI_CLK_PERIOD_NS)
`define SAHI_WORD_BITS 16
`define SAHI_LEAD_ZEROS 4'h0
`define SAHI_UPPER_PAD 4'h0
`endif

// File: hdl/sahi_pkg.sv
// Types shared by the converter host interface.
// Assumes sahi_regs.svh supplies the numeric constants.
package sahi_pkg;
    typedef enum logic [0:0] {
        SAHI_IDLE = 1'b0,
        SAHI_CONV = 1'b1
    } sahi_state_e;
    typedef enum logic [1:0] {
        SAHI_FMT_WORD = 2'b00,
        SAHI_FMT_GATED = 2'b01,
        SAHI_FMT_CONT = 2'b10
    } sahi_fmt_e;
    typedef struct packed {
        logic ext_clk;
        sahi_fmt_e fmt;
    } sahi_ctrl_s;
    typedef struct packed {
        logic tracking;
        logic mode2;
        logic irq_pending;
        logic converting;
    } sahi_status_s;
    typedef logic [11:0] sahi_code_t;
endpackage

// File: hdl/sahi_top.sv
// Conversion control and result output of a 12-bit sampling converter.
// Assumes host pins are asynchronous and an APB master on CLK.
//
// Notes on behaviour
// - Mode 1: trigger rising edge holds the sample and starts conversion.
// - Track/hold returns to tracking when conversion completes.
// - Mode 1: trigger edge ignored while chip select is low.
// - Mode 1: status pin idles high, goes low when conversion finishes.
// - Read falling edge returns interrupt high; result is driven then.
// - Output latches stay disabled while converting.
// - Interrupt comes up pending; host clears it with a dummy read.
// - Trigger held low selects mode 2; chip select falling with upper byte select low starts conversion.
// - Word format offers only parallel output; others enable byte/serial.
// - Word format drives all twelve result bits at once.
// - Byte select low gives low byte; high gives upper nibble.
// - Serial word: four zeros then twelve result bits, MSB first.
// - Serial bits change on shift clock rise, valid on its fall.
// - Frame strobe low within three converter clocks of the trigger.
// - Serial lines are open drain: pulled low or released.
// - Shift clock derives from internal or external converter clock.
// - Continuous format runs shift clock always; gated stops it.
// - Byte mode: first read clears interrupt, byte chosen by select.
// - Word format produces no serial output.
// - All formats work in both modes.
// - Mode 2: busy low from start to end of conversion.
`timescale 1ns/1ps
`include "sahi_regs.svh"
module sahi_top
    import sahi_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Host control pins
    input wire logic SAMPLE_TRIGGER_N,
    input wire logic CS_N,
    input wire logic RD_N,
    input wire logic UPPER_BYTE_SELECT,
    input wire logic CONV_CLK_EXT,
    // Analog core
    input wire sahi_pkg::sahi_code_t ANALOG_CODE,
    output logic HOLD,
    // Status and result bus
    output logic STATUS_N,
    output logic [11:0] RESULT_BUS_O,
    output logic [11:0] RESULT_BUS_OE,
    // Open-drain serial lines
    output logic FRAME_STROBE_N_O,
    output logic FRAME_STROBE_N_OE,
    output logic SHIFT_CLOCK_OUT_O,
    output logic SHIFT_CLOCK_OUT_OE,
    output logic SHIFT_DATA_OUT_O,
    output logic SHIFT_DATA_OUT_OE
);
    import sahi_pkg::*;

    localparam logic [7:0] HALF_CYC = 8'(`SAHI_HALF_CYC);
    localparam logic [4:0] WORD_BITS = 5'(`SAHI_WORD_BITS);

    function automatic logic [1:0] reg_sel(input logic [7:0] a);
        if (a == `SAHI_OFF_CTRL)
            reg_sel = 2'h1;
        else if (a == `SAHI_OFF_STATUS)
            reg_sel = 2'h2;
        else if (a == `SAHI_OFF_RESULT)
            reg_sel = 2'h3;
        else
            reg_sel = 2'h0;
    endfunction

    sahi_ctrl_s ctrl_r;
    sahi_status_s stat;
    sahi_state_e state_r;
    sahi_state_e state_nxt;
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic trig_d_r;
    logic cs_d_r;
    logic ext_d_r;
    logic rd_d_r;
    logic trig_s;
    logic cs_s;
    logic rd_s;
    logic hb_s;
    logic ext_s;
    logic [7:0] div_r;
    logic int_lvl_r;
    logic conv_lvl;
    logic conv_rise;
    logic trig_rise;
    logic cs_fall;
    logic rd_act;
    logic rd_fall;
    logic start1;
    logic start2;
    logic conv_end;
    logic mode2_r;
    logic irq_r;
    logic hold_r;
    logic frame_r;
    logic shift_data_out_r;
    logic [15:0] shreg_r;
    logic [4:0] bit_cnt_r;
    sahi_code_t result_r;
    logic status_n_r;
    logic [11:0] bus_o_r;
    logic [11:0] bus_oe_r;
    logic frame_oe_r;
    logic sclk_oe_r;
    logic shift_data_out_oe_r;
    logic od_low_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic serial_en;
    logic sclk_run;

    // Two-flop synchronisers for the host pins and external clock
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_sync
            always_ff @(posedge CLK)
            begin
                if (!RESETN)
                begin
                    sync1_r[gi] <= 1'b1;
                    sync2_r[gi] <= 1'b1;
                end
                else
                begin
                    sync1_r[gi] <= (gi == 0) ? SAMPLE_TRIGGER_N :
                                   (gi == 1) ? CS_N :
                                   (gi == 2) ? RD_N :
                                   (gi == 3) ? UPPER_BYTE_SELECT :
                                   CONV_CLK_EXT;
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    assign trig_s = sync2_r[0];
    assign cs_s = sync2_r[1];
    assign rd_s = sync2_r[2];
    assign hb_s = sync2_r[3];
    assign ext_s = sync2_r[4];

    // Edge history of synchronised pins
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            trig_d_r <= 1'b1;
            cs_d_r <= 1'b1;
            ext_d_r <= 1'b1;
            rd_d_r <= 1'b0;
        end
        else
        begin
            trig_d_r <= trig_s;
            cs_d_r <= cs_s;
            ext_d_r <= ext_s;
            rd_d_r <= rd_act;
        end
    end

    assign trig_rise = trig_s & ~trig_d_r;
    assign cs_fall = ~cs_s & cs_d_r;
    assign rd_act = ~cs_s & ~rd_s;
    assign rd_fall = rd_act & ~rd_d_r;

    // Internal converter clock divider
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            div_r <= 8'h00;
            int_lvl_r <= 1'b0;
        end
        else if (div_r == HALF_CYC - 8'h01)
        begin
            div_r <= 8'h00;
            int_lvl_r <= ~int_lvl_r;
        end
        else
            div_r <= div_r + 8'h01;
    end

    // Converter clock source select
    always_comb
    begin
        if (ctrl_r.ext_clk)
        begin
            conv_lvl = ext_s;
            conv_rise = ext_s & ~ext_d_r;
        end
        else
        begin
            conv_lvl = int_lvl_r;
            conv_rise = (div_r == HALF_CYC - 8'h01) & ~int_lvl_r;
        end
    end

    assign start1 = trig_rise & cs_s;
    assign start2 = cs_fall & ~trig_s & ~hb_s;
    assign conv_end = (state_r == SAHI_CONV) & conv_rise &
                      (bit_cnt_r == WORD_BITS);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            SAHI_IDLE:
                if (start1 | start2)
                    state_nxt = SAHI_CONV;
            SAHI_CONV:
                if (conv_end)
                    state_nxt = SAHI_IDLE;
            default:
                state_nxt = SAHI_IDLE;
        endcase
    end

    // Conversion sequencer
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            state_r <= SAHI_IDLE;
            mode2_r <= 1'b0;
            hold_r <= 1'b0;
            result_r <= 12'h000;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_r == SAHI_IDLE && (start1 | start2))
            begin
                mode2_r <= start2 & ~start1;
                hold_r <= 1'b1;
            end
            else if (conv_end)
            begin
                hold_r <= 1'b0;
                result_r <= shreg_r[11:0];
            end
        end
    end

    // Serial word shifter
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            shreg_r <= 16'h0000;
            bit_cnt_r <= 5'h00;
            frame_r <= 1'b0;
            shift_data_out_r <= 1'b0;
        end
        else if (state_r == SAHI_IDLE && (start1 | start2))
        begin
            shreg_r <= {`SAHI_LEAD_ZEROS, ANALOG_CODE};
            bit_cnt_r <= 5'h00;
        end
        else if (state_r == SAHI_CONV && conv_rise)
        begin
            if (conv_end)
                frame_r <= 1'b0;
            else
            begin
                frame_r <= 1'b1;
                shift_data_out_r <= shreg_r[15 - bit_cnt_r[3:0]];
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
        end
    end

    // Interrupt flag, set at end of a mode 1 conversion
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
            irq_r <= 1'b1;
        else if (conv_end && !mode2_r)
            irq_r <= 1'b1;
        else if (rd_fall)
            irq_r <= 1'b0;
    end

    // Shared status pin: busy in mode 2, interrupt in mode 1
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
            status_n_r <= 1'b0;
        else if (state_r == SAHI_IDLE && start2)
            status_n_r <= 1'b0;
        else if (mode2_r && state_r == SAHI_CONV && !conv_end)
            status_n_r <= 1'b0;
        else if (mode2_r)
            status_n_r <= 1'b1;
        else if (conv_end)
            status_n_r <= 1'b0;
        else if (rd_fall)
            status_n_r <= 1'b1;
        else
            status_n_r <= ~irq_r;
    end

    // Parallel result latches
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            bus_o_r <= 12'h000;
            bus_oe_r <= 12'h000;
        end
        else if (rd_act && state_nxt == SAHI_IDLE &&
                 state_r == SAHI_IDLE)
        begin
            if (ctrl_r.fmt == SAHI_FMT_WORD)
            begin
                bus_o_r <= result_r;
                bus_oe_r <= 12'hFFF;
            end
            else
            begin
                bus_oe_r <= 12'h0FF;
                if (hb_s)
                    bus_o_r <= {4'h0, `SAHI_UPPER_PAD,
                                result_r[11:8]};
                else
                    bus_o_r <= {4'h0, result_r[7:0]};
            end
        end
        else
            bus_oe_r <= 12'h000;
    end

    assign serial_en = ctrl_r.fmt != SAHI_FMT_WORD;
    assign sclk_run = (ctrl_r.fmt == SAHI_FMT_CONT) |
                      ((ctrl_r.fmt == SAHI_FMT_GATED) & frame_r);

    // Open-drain serial drivers: enable pulls the line low
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            frame_oe_r <= 1'b0;
            sclk_oe_r <= 1'b0;
            shift_data_out_oe_r <= 1'b0;
            od_low_r <= 1'b0;
        end
        else
        begin
            frame_oe_r <= serial_en & frame_r;
            sclk_oe_r <= serial_en & sclk_run & ~conv_lvl;
            shift_data_out_oe_r <= serial_en & frame_r & ~shift_data_out_r;
            od_low_r <= 1'b0;
        end
    end

    // APB slave, one wait state per access
    always_ff @(posedge CLK)
    begin
        if (!RESETN)
        begin
            ctrl_r <= sahi_ctrl_s'(`SAHI_CTRL_RESET);
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else if (PSEL && PENABLE && !pready_r)
        begin
            pready_r <= 1'b1;
            pslverr_r <= reg_sel(PADDR) == 2'h0;
            prdata_r <= 32'h0000_0000;
            if (PWRITE && reg_sel(PADDR) == 2'h1)
                ctrl_r <= sahi_ctrl_s'(PWDATA[2:0]);
            else if (!PWRITE && reg_sel(PADDR) == 2'h1)
                prdata_r <= {29'h0, ctrl_r};
            else if (!PWRITE && reg_sel(PADDR) == 2'h2)
                prdata_r <= {28'h0, stat};
            else if (!PWRITE && reg_sel(PADDR) == 2'h3)
                prdata_r <= {20'h0, result_r};
        end
        else
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    always_comb
    begin
        stat.tracking = ~hold_r;
        stat.mode2 = mode2_r;
        stat.irq_pending = irq_r;
        stat.converting = state_r == SAHI_CONV;
    end

    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign HOLD = hold_r;
    assign STATUS_N = status_n_r;
    assign RESULT_BUS_O = bus_o_r;
    assign RESULT_BUS_OE = bus_oe_r;
    assign FRAME_STROBE_N_O = od_low_r;
    assign FRAME_STROBE_N_OE = frame_oe_r;
    assign SHIFT_CLOCK_OUT_O = od_low_r;
    assign SHIFT_CLOCK_OUT_OE = sclk_oe_r;
    assign SHIFT_DATA_OUT_O = od_low_r;
    assign SHIFT_DATA_OUT_OE = shift_data_out_oe_r;

    // Checks
    localparam int FRAME_MAX = 320;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    sequence s_start1;
        state_r == SAHI_IDLE && start1;
    endsequence
    sequence s_end1;
        conv_end && !mode2_r;
    endsequence

    a_hold_on_trigger: assert property (
        s_start1 |=> HOLD && state_r == SAHI_CONV)
        else $error("hold not taken on trigger edge");
    a_track_after_done: assert property (
        conv_end |=> !HOLD ##1 !HOLD)
        else $error("track not resumed after conversion");
    a_cs_blocks_start: assert property (
        state_r == SAHI_IDLE && trig_rise && !cs_s && !start2
        |=> state_r == SAHI_IDLE)
        else $error("conversion started with chip select low");
    a_irq_at_done: assert property (
        s_end1 |=> ##1 !STATUS_N)
        else $error("interrupt not asserted at end");
    a_irq_clear_read: assert property (
        rd_fall && !conv_end && !mode2_r |=> !irq_r)
        else $error("interrupt not cleared by read");
    a_latch_off_conv: assert property (
        state_r == SAHI_CONV |=> RESULT_BUS_OE == 12'h000)
        else $error("result driven during conversion");
    a_byte_upper: assert property (
        RESULT_BUS_OE == 12'h0FF && $past(hb_s)
        |-> RESULT_BUS_O[7:4] == 4'h0)
        else $error("upper byte not right justified");
    a_no_serial_word: assert property (
        $past(ctrl_r.fmt) == SAHI_FMT_WORD
        |-> !SHIFT_CLOCK_OUT_OE && !SHIFT_DATA_OUT_OE
            && !FRAME_STROBE_N_OE)
        else $error("serial output in word format");
    a_frame_start: assert property (
        s_start1 |-> ##[1:FRAME_MAX] frame_r)
        else $error("frame strobe late");
    a_busy_mode2: assert property (
        mode2_r && state_r == SAHI_CONV && !conv_end |=> !STATUS_N)
        else $error("busy not low during conversion");
endmodule

// File: sim/sahi_host_model.sv
// Host model: drives the converter control pins, receives serial words.
// Assumes pull-ups on the open-drain lines and the shared system clock.
`timescale 1ns/1ps
module sahi_host_model (
    // Clock
    input wire logic clk,
    // Open-drain enables from the converter
    input wire logic strobe_oe,
    input wire logic sclk_oe,
    input wire logic shift_data_out_oe,
    // Host pins
    output logic trig_n,
    output logic cs_n,
    output logic rd_n,
    output logic ubs,
    // Received serial data
    output logic [15:0] word,
    output int frames,
    output int nbits,
    output int sclk_falls
);
    // Line levels with pull-ups
    wire logic strb = ~strobe_oe;
    wire logic sclk = ~sclk_oe;
    wire logic sdat = ~shift_data_out_oe;
    logic strb_q = 1'b1;
    logic sclk_q = 1'b1;

    initial
    begin
        trig_n = 1'b1;
        cs_n = 1'b1;
        rd_n = 1'b1;
        ubs = 1'b0;
        word = 16'h0000;
        frames = 0;
        nbits = 0;
        sclk_falls = 0;
    end

    // Bit taken on the falling serial clock while framed
    always @(posedge clk)
    begin
        strb_q <= strb;
        sclk_q <= sclk;
        if (strb_q && !strb)
        begin
            frames <= frames + 1;
            nbits <= 0;
        end
        if (sclk_q && !sclk)
        begin
            sclk_falls <= sclk_falls + 1;
            if (!strb)
            begin
                word <= {word[14:0], sdat};
                nbits <= nbits + 1;
            end
        end
    end

    // Pins change only just after a rising edge, always actively driven
    task automatic pins(input logic t, input logic c, input logic r,
                        input logic u);
        @(posedge clk);
        trig_n <= t;
        cs_n <= c;
        rd_n <= r;
        ubs <= u;
    endtask
endmodule

// File: sim/sampling_adc_host_interface_tb.sv
// Self-checking bench for the converter host interface.
// Assumes the host model drives the pins; APB is driven here.
`timescale 1ns/1ps
`include "sahi_regs.svh"
module sampling_adc_host_interface_tb;
    import sahi_pkg::*;
    logic clk = 1'b0;
    logic conv_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, hold, status_n, trig_n, cs_n, rd_n, ubs, err_q;
    sahi_code_t code_in = 12'h000;
    logic [11:0] bus_o, bus_oe;
    logic fs_o, fs_oe, sc_o, sc_oe, sd_o, sd_oe;
    logic [15:0] word;
    logic [31:0] rd_q;
    int frames, nbits, falls;
    int fail_count = 0;
    int num_checks = 0;
    wire logic [2:0] mon = {~fs_oe, status_n, hold};

    always #2 clk = ~clk;
    always #62.5 conv_clk = ~conv_clk;

    sahi_top DUT (.CLK(clk), .RESETN(resetn), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SAMPLE_TRIGGER_N(trig_n), .CS_N(cs_n),
        .RD_N(rd_n), .UPPER_BYTE_SELECT(ubs), .CONV_CLK_EXT(conv_clk),
        .ANALOG_CODE(code_in), .HOLD(hold), .STATUS_N(status_n),
        .RESULT_BUS_O(bus_o), .RESULT_BUS_OE(bus_oe),
        .FRAME_STROBE_N_O(fs_o), .FRAME_STROBE_N_OE(fs_oe),
        .SHIFT_CLOCK_OUT_O(sc_o), .SHIFT_CLOCK_OUT_OE(sc_oe),
        .SHIFT_DATA_OUT_O(sd_o), .SHIFT_DATA_OUT_OE(sd_oe));

    sahi_host_model host (.clk(clk), .strobe_oe(fs_oe), .sclk_oe(sc_oe),
        .shift_data_out_oe(sd_oe), .trig_n(trig_n), .cs_n(cs_n), .rd_n(rd_n),
        .ubs(ubs), .word(word), .frames(frames), .nbits(nbits),
        .sclk_falls(falls));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            chk(0, 1);
            conclude();
        end
    endtask

    // Bounded wait for HOLD (0), STATUS_N (1) or frame line (2)
    task automatic wait_on(input int i, input logic v, input int lim);
        int n;
        n = 0;
        while (mon[i] !== v && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        if (mon[i] !== v)
        begin
            chk(0, 1);
            conclude();
        end
    endtask

    function automatic logic [11:0] exp_bus(input logic [11:0] c,
                                            input logic [1:0] f,
                                            input logic u);
        if (f == 2'b00)
            return c;
        return u ? {8'h00, c[11:8]} : {4'h0, c[7:0]};
    endfunction

    task automatic read_chk(input logic t, input logic u,
                            input logic [1:0] f, input logic [11:0] c);
        host.pins(t, 1'b0, 1'b0, u);
        repeat (8) @(negedge clk);
        chk(bus_oe, f == 2'b00 ? 12'hfff : 12'h0ff);
        chk(bus_o & bus_oe, exp_bus(c, f, u));
        chk(status_n, 1'b1);
        host.pins(t, 1'b1, 1'b1, u);
        repeat (6) @(negedge clk);
        chk(bus_oe, 12'h000);
    endtask

    task automatic run_conv(input logic [1:0] f, input logic m2,
                            input logic u, input logic ext);
        sahi_code_t c;
        int fr;
        int e;
        c = sahi_code_t'($urandom);
        fr = frames;
        apb(1'b1, `SAHI_OFF_CTRL, {29'h0, ext, f});
        apb(1'b0, `SAHI_OFF_CTRL, 32'h0000_0000);
        chk(rd_q, {29'h0, ext, f});
        @(posedge clk);
        code_in <= c;
        if (m2)
        begin
            host.pins(1'b0, 1'b1, 1'b1, 1'b0);
            host.pins(1'b0, 1'b0, 1'b1, 1'b0);
            @(negedge clk);
            wait_on(1, 1'b0, 10);
            chk(hold, 1'b1);
        end
        else
        begin
            host.pins(1'b0, 1'b1, 1'b1, u);
            host.pins(1'b0, 1'b1, 1'b1, u);
            host.pins(1'b1, 1'b1, 1'b1, u);
            @(negedge clk);
            wait_on(0, 1'b1, 10);
        end
        if (f != 2'b00)
        begin
            wait_on(2, 1'b0, ext ? 100 : 320);
            chk({fs_o, sc_o, sd_o}, 3'b000);
        end
        if (!m2)
        begin
            host.pins(1'b1, 1'b0, 1'b0, u);
            repeat (6) @(negedge clk);
            chk(bus_oe, 12'h000);
            host.pins(1'b1, 1'b1, 1'b1, u);
        end
        wait_on(0, 1'b0, 4000);
        repeat (4) @(negedge clk);
        chk(status_n, m2);
        if (f != 2'b00)
        begin
            chk(nbits, 16);
            chk(word, {4'h0, c});
        end
        else
            chk(frames, fr);
        read_chk(~m2, m2 ? 1'b0 : u, f, c);
        read_chk(~m2, m2 | ~u, f, c);
        if (m2)
        begin
            host.pins(1'b0, 1'b0, 1'b1, 1'b1);
            host.pins(1'b1, 1'b0, 1'b1, 1'b1);
            host.pins(1'b1, 1'b1, 1'b1, 1'b1);
        end
        e = falls;
        repeat (300) @(negedge clk);
        chk(hold, 1'b0);
        chk(falls != e, f == 2'b10);
        apb(1'b0, `SAHI_OFF_RESULT, 32'h0000_0000);
        chk(rd_q, {20'h0_0000, c});
    endtask

    initial
    begin
        void'($urandom(32'h0000_4bba));
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk(status_n, 1'b0);
        chk({hold, bus_oe}, 32'h0000_0000);
        apb(1'b0, `SAHI_OFF_CTRL, 32'h0000_0000);
        chk(rd_q, `SAHI_CTRL_RESET);
        host.pins(1'b1, 1'b0, 1'b0, 1'b0);
        repeat (8) @(negedge clk);
        chk(status_n, 1'b1);
        host.pins(1'b1, 1'b1, 1'b1, 1'b0);
        apb(1'b0, `SAHI_OFF_STATUS, 32'h0000_0000);
        chk(rd_q, 32'h0000_0008);
        apb(1'b0, 8'h0c, 32'h0000_0000);
        chk(err_q, 1'b1);
        chk(rd_q, 32'h0000_0000);
        host.pins(1'b1, 1'b0, 1'b1, 1'b0);
        host.pins(1'b0, 1'b0, 1'b1, 1'b0);
        host.pins(1'b1, 1'b0, 1'b1, 1'b0);
        repeat (150) @(negedge clk);
        chk(hold, 1'b0);
        host.pins(1'b1, 1'b1, 1'b1, 1'b0);
        run_conv(2'b00, 1'b0, 1'b0, 1'b1);
        run_conv(2'b01, 1'b0, 1'b1, 1'b1);
        run_conv(2'b10, 1'b0, 1'b0, 1'b1);
        run_conv(2'b01, 1'b1, 1'b0, 1'b1);
        run_conv(2'b00, 1'b1, 1'b0, 1'b1);
        run_conv(2'b10, 1'b1, 1'b0, 1'b1);
        run_conv(2'b01, 1'b0, 1'b1, 1'b0);
        for (int i = 0; i < 6; i++)
            run_conv(2'($urandom_range(2)), 1'($urandom), 1'($urandom),
                     1'b1);
        conclude();
    end
endmodule
